/* File: lcd_host_port.v */
// host command/data port: 8080 parallel and serial links
`timescale 1ns/1ns
`default_nettype none
`include "lcd_host_regs.vh"
module lcd_host_port #(
    parameter PIX_DEPTH = `PIX_DEPTH
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // host pins
    input wire [3:0] interface_select_pins_i,
    input wire chip_select_n_i,
    input wire write_strobe_n_i,
    input wire read_strobe_n_i,
    input wire cmd_data_pin_i,
    input wire [8:0] data_i,
    output reg [8:0] data_o,
    output wire [8:0] data_oe_n_o,
    input wire sda_i,
    output reg sda_o,
    output wire sda_oe_n_o,
    output reg serial_data_out_o,
    output wire serial_data_out_oe_n_o,
    // decoded commands and parameters
    output reg cmd_valid_o,
    output reg [7:0] cmd_o,
    output reg param_valid_o,
    output reg [7:0] param_o,
    // display RAM write stream
    output wire ram_valid_o,
    input wire ram_ready_i,
    output wire [8:0] ram_data_o,
    output reg ram_overflow_o,
    // read-back sources
    input wire [31:0] reg_rd_data_i,
    input wire [8:0] ram_rd_data_i,
    output reg ram_rd_pulse_o,
    // status
    output reg two_lane_o,
    output reg mode_reserved_o
);
    // synchronised pins
    wire [17:0] pins_s;
    wire [3:0] mode_s;
    wire cs_n_s;
    wire wr_n_s;
    wire rd_n_s;
    wire dcx_s;
    wire sda_s;
    wire [8:0] bus_s;
    reg wr_prev_q;
    reg rd_prev_q;
    reg dcx_prev_q;
    // byte assembly and read state
    reg [3:0] dcnt_q;
    reg flag_got_q;
    reg sflag_q;
    reg [7:0] sh_q;
    reg srd_q;
    reg sloaded_q;
    reg [5:0] rbits_q;
    reg [31:0] sout_q;
    reg pdrive_q;
    reg [1:0] pidx_q;
    reg ram_wr_q;
    // fifo fill side
    reg fifo_valid;
    reg [8:0] fifo_data;
    wire fifo_ready;
    // dispatch of one finished byte
    reg byte_done;
    reg byte_flag;
    reg [8:0] byte_val;

    function [2:0] mode_class;
        input [3:0] m;
        begin
            case (m)
                `IF_PAR8: mode_class = 3'h1;
                `IF_PAR9: mode_class = 3'h2;
                `IF_SER3: mode_class = 3'h3;
                `IF_SER3_SDO: mode_class = 3'h3;
                `IF_SER4: mode_class = 3'h4;
                `IF_SER4_SDO: mode_class = 3'h4;
                default: mode_class = 3'h0;
            endcase
        end
    endfunction

    function [5:0] read_len;
        input [7:0] c;
        begin
            if (c == `CMD_ID_ALL) begin
                read_len = `RD_LEN_ID;
            end else if (c == `CMD_STATUS_ALL) begin
                read_len = `RD_LEN_STATUS;
            end else if ((c >= `CMD_STAT_FIRST && c <= `CMD_STAT_LAST) || c == `CMD_ID_ONE
                    || c == `CMD_ID_TWO || c == `CMD_ID_THREE) begin
                read_len = `RD_LEN_SHORT;
            end else begin
                read_len = 6'h00;
            end
        end
    endfunction

    // all host pins treated as asynchronous
    pin_sync #(.W(18)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i({interface_select_pins_i, chip_select_n_i, write_strobe_n_i, read_strobe_n_i,
                  cmd_data_pin_i, sda_i, data_i}),
        .sync_o(pins_s)
    );
    assign mode_s = pins_s[17:14];
    assign cs_n_s = pins_s[13];
    assign wr_n_s = pins_s[12];
    assign rd_n_s = pins_s[11];
    assign dcx_s = pins_s[10];
    assign sda_s = pins_s[9];
    assign bus_s = pins_s[8:0];
    wire [2:0] mcls = mode_class(mode_s);
    wire is_par = (mcls == 3'h1) || (mcls == 3'h2);
    wire is_nine = (mcls == 3'h2);
    wire is_ser3 = (mcls == 3'h3);
    wire is_ser = is_ser3 || (mcls == 3'h4);
    wire sep_out = (mode_s == `IF_SER3_SDO) || (mode_s == `IF_SER4_SDO);
    wire cs_act = ~cs_n_s;
    // write edge and read falling edge gated by chip select
    wire wr_rise = is_par & cs_act & wr_n_s & ~wr_prev_q;
    wire rd_fall = is_par & cs_act & ~rd_n_s & rd_prev_q;
    wire rd_rise = rd_n_s & ~rd_prev_q;
    // serial clock arrives on the flag pin
    wire sclk_rise = is_ser & cs_act & dcx_s & ~dcx_prev_q;
    wire sclk_fall = is_ser & cs_act & ~dcx_s & dcx_prev_q;
    // both lanes used for RAM data in 2-lane mode
    wire lane_pair = two_lane_o & is_ser3 & ram_wr_q & sflag_q;
    wire [3:0] dcnt_step = lane_pair ? 4'h2 : 4'h1;
    wire [3:0] dcnt_next = dcnt_q + dcnt_step;
    // lane one carries the higher bit of each pair
    wire [7:0] sh_next = lane_pair ? {sh_q[5:0], sda_s, wr_n_s} : {sh_q[6:0], sda_s};
    wire data_edge = sclk_rise & ~srd_q & ~(is_ser3 & ~flag_got_q);
    // finished byte from either port
    always @* begin
        byte_done = 1'b0;
        byte_flag = 1'b0;
        byte_val = 9'h000;
        if (wr_rise) begin
            // capture at write strobe rising edge
            byte_done = 1'b1;
            byte_flag = dcx_s;
            // ninth line only for RAM data
            byte_val = (is_nine & dcx_s & ram_wr_q) ? bus_s : {1'b0, bus_s[7:0]};
        end else if (data_edge && dcnt_next >= `SER_BYTE_BITS) begin
            byte_done = 1'b1;
            // 4-line flag sampled on eighth edge
            byte_flag = is_ser3 ? sflag_q : wr_n_s;
            byte_val = {1'b0, sh_next};
        end
    end
    // edge history starts at the synchronisers' idle level
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
            dcx_prev_q <= 1'b1;
            mode_reserved_o <= 1'b0;
        end else begin
            wr_prev_q <= wr_n_s;
            rd_prev_q <= rd_n_s;
            dcx_prev_q <= dcx_s;
            mode_reserved_o <= (mcls == 3'h0);
        end
    end
    // serial packet assembly
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dcnt_q <= 4'h0;
            flag_got_q <= 1'b0;
            sflag_q <= 1'b0;
            sh_q <= 8'h00;
        end else if (cs_n_s | ~is_ser) begin
            // idle or aborted: partial bits dropped
            dcnt_q <= 4'h0;
            flag_got_q <= 1'b0;
            sh_q <= 8'h00;
        end else if (sclk_rise & ~srd_q) begin
            if (is_ser3 & ~flag_got_q) begin
                // flag bit leads the 3-line packet
                sflag_q <= sda_s;
                flag_got_q <= 1'b1;
            end else if (byte_done) begin
                // next edge starts the next packet
                dcnt_q <= 4'h0;
                flag_got_q <= 1'b0;
                sh_q <= 8'h00;
            end else begin
                sh_q <= sh_next;
                dcnt_q <= dcnt_next;
            end
        end
    end
    // command, parameter and RAM dispatch
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_valid_o <= 1'b0;
            cmd_o <= 8'h00;
            param_valid_o <= 1'b0;
            param_o <= 8'h00;
            ram_wr_q <= 1'b0;
            two_lane_o <= 1'b0;
            ram_overflow_o <= 1'b0;
        end else begin
            cmd_valid_o <= 1'b0;
            param_valid_o <= 1'b0;
            ram_overflow_o <= 1'b0;
            if (mode_s != `IF_SER3) begin
                two_lane_o <= 1'b0;
            end
            if (byte_done & ~byte_flag) begin
                cmd_o <= byte_val[7:0];
                cmd_valid_o <= 1'b1;
                ram_wr_q <= (byte_val[7:0] == `CMD_MEM_WRITE);
            end else if (byte_done & ram_wr_q) begin
                ram_overflow_o <= ~fifo_ready;
            end else if (byte_done) begin
                param_o <= byte_val[7:0];
                param_valid_o <= 1'b1;
                if (cmd_o == `CMD_LANE_CFG && mode_s == `IF_SER3) begin
                    two_lane_o <= (byte_val[7:0] == `LANE_CFG_TWO);
                end
            end
        end
    end
    always @* begin
        fifo_valid = byte_done & byte_flag & ram_wr_q;
        fifo_data = byte_val;
    end
    pixel_fifo #(.WIDTH(`PIX_WIDTH), .DEPTH(PIX_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_valid_i(fifo_valid),
        .in_ready_o(fifo_ready),
        .in_data_i(fifo_data),
        .out_valid_o(ram_valid_o),
        .out_ready_i(ram_ready_i),
        .out_data_o(ram_data_o)
    );
    // serial read-back
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            srd_q <= 1'b0;
            sloaded_q <= 1'b0;
            rbits_q <= 6'h00;
            sout_q <= 32'h00000000;
            sda_o <= 1'b0;
            serial_data_out_o <= 1'b0;
        end else if (cs_n_s | ~is_ser) begin
            // read ends when chip select rises
            srd_q <= 1'b0;
            sloaded_q <= 1'b0;
            rbits_q <= 6'h00;
        end else if (byte_done & ~byte_flag & is_ser) begin
            // read command turns the line round
            srd_q <= (read_len(byte_val[7:0]) != 6'h00);
            rbits_q <= read_len(byte_val[7:0]);
            sloaded_q <= 1'b0;
        end else if (sclk_fall & srd_q & rbits_q != 6'h00) begin
            if (sloaded_q) begin
                sda_o <= sout_q[31];
                serial_data_out_o <= sout_q[31];
                sout_q <= {sout_q[30:0], 1'b0};
            end else begin
                sda_o <= reg_rd_data_i[31];
                serial_data_out_o <= reg_rd_data_i[31];
                sout_q <= {reg_rd_data_i[30:0], 1'b0};
                sloaded_q <= 1'b1;
            end
            rbits_q <= rbits_q - 6'h01;
        end else if (sclk_fall & srd_q) begin
            srd_q <= 1'b0;
        end
    end

    // drive only after the command's last falling edge
    wire ser_drive = srd_q & sloaded_q;
    // separate-output variants keep the data pin input only
    assign sda_oe_n_o = ~(ser_drive & ~sep_out);
    assign serial_data_out_oe_n_o = ~(ser_drive & sep_out);

    // parallel read-back
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pdrive_q <= 1'b0;
            pidx_q <= 2'h0;
            data_o <= 9'h000;
            ram_rd_pulse_o <= 1'b0;
        end else begin
            ram_rd_pulse_o <= 1'b0;
            if (byte_done & ~byte_flag) begin
                pidx_q <= 2'h0;
            end
            if (cs_n_s | ~is_par | rd_rise) begin
                pdrive_q <= 1'b0;
            end else if (rd_fall) begin
                // bus driven after read strobe falls
                pdrive_q <= 1'b1;
                if (cmd_o == `CMD_MEM_READ) begin
                    // RAM reads use nine lines in 9-bit mode
                    data_o <= is_nine ? ram_rd_data_i : {1'b0, ram_rd_data_i[7:0]};
                    ram_rd_pulse_o <= 1'b1;
                end else begin
                    case (pidx_q)
                        2'h0: data_o <= {1'b0, reg_rd_data_i[31:24]};
                        2'h1: data_o <= {1'b0, reg_rd_data_i[23:16]};
                        2'h2: data_o <= {1'b0, reg_rd_data_i[15:8]};
                        default: data_o <= {1'b0, reg_rd_data_i[7:0]};
                    endcase
                    pidx_q <= pidx_q + 2'h1;
                end
            end
        end
    end

    assign data_oe_n_o = ~{pdrive_q & is_nine, {8{pdrive_q}}};
endmodule
`default_nettype wire

/* File: lcd_host_regs.vh */
// constants of the display controller host interface
`ifndef LCD_HOST_REGS_VH
`define LCD_HOST_REGS_VH

// interface select codes
`define IF_PAR8 4'h0
`define IF_PAR9 4'h2
`define IF_SER3 4'h5
`define IF_SER4 4'h6
`define IF_SER3_SDO 4'hd
`define IF_SER4_SDO 4'he

// commands the interface itself reacts to
`define CMD_MEM_WRITE 8'h2c
`define CMD_MEM_READ 8'h2e
`define CMD_LANE_CFG 8'he7
`define LANE_CFG_TWO 8'h10
`define CMD_STAT_FIRST 8'h0a
`define CMD_STAT_LAST 8'h0f
`define CMD_ID_ALL 8'h04
`define CMD_STATUS_ALL 8'h09
`define CMD_ID_ONE 8'hda
`define CMD_ID_TWO 8'hdb
`define CMD_ID_THREE 8'hdc

// serial packet and read lengths in bits
`define SER_BYTE_BITS 4'h8
`define RD_LEN_SHORT 6'h08
`define RD_LEN_ID 6'h18
`define RD_LEN_STATUS 6'h20

// pixel buffer geometry
`define PIX_WIDTH 9
`define PIX_DEPTH 16

`endif

/* File: pin_sync.v */
// two-stage synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // pins and synchronised copy
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_o
);
    reg [W-1:0] meta_q;

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= {W{1'b1}};
            sync_o <= {W{1'b1}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* File: pixel_fifo.v */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pixel_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16
) (
    // clock and reset
    input wire ref_clk_i,
    input wire rst_i,
    // fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    localparam AW = $clog2(DEPTH);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_q;
    reg [AW-1:0] rd_ptr_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;

    assign in_ready_o = (count_q != DEPTH[AW:0]);
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr_q];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push & ~pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop & ~push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: lcd_host_props.sv */
// assertions on the display host port pins
`timescale 1ns/1ns
`default_nettype none
module lcd_host_props (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // watched pins
    input wire logic [3:0] interface_select_pins_i,
    input wire logic chip_select_n_i,
    input wire logic read_strobe_n_i,
    input wire logic [8:0] data_oe_n_o,
    input wire logic sda_oe_n_o,
    input wire logic serial_data_out_oe_n_o,
    input wire logic cmd_valid_o,
    input wire logic param_valid_o,
    input wire logic ram_valid_o,
    input wire logic ram_ready_i,
    input wire logic [8:0] ram_data_o,
    input wire logic ram_overflow_o,
    input wire logic ram_rd_pulse_o,
    input wire logic two_lane_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    a_cmd_one_cycle: assert property (cmd_valid_o |=> !cmd_valid_o)
        else $error("command pulse longer than one cycle");
    a_quiet_deselect: assert property (chip_select_n_i [*8] |-> !cmd_valid_o && !param_valid_o)
        else $error("byte taken while deselected");
    a_read_drive: assert property (!data_oe_n_o[0] |-> !$past(read_strobe_n_i, 3) || !$past(read_strobe_n_i, 4))
        else $error("bus driven without read strobe");
    a_par_mode_drive: assert property (!data_oe_n_o[0] |-> interface_select_pins_i[3:2] == 2'b00)
        else $error("parallel bus driven in serial mode");
    a_bit8_nine: assert property (!data_oe_n_o[8] |-> interface_select_pins_i == 4'h2)
        else $error("ninth line driven outside 9-bit mode");
    a_sda_shared: assert property (!sda_oe_n_o |-> interface_select_pins_i == 4'h5 || interface_select_pins_i == 4'h6)
        else $error("shared line driven in wrong mode");
    a_sdo_separate: assert property (!serial_data_out_oe_n_o |-> interface_select_pins_i[3])
        else $error("output pin driven in wrong mode");
    a_fifo_hold: assert property (ram_valid_o && !ram_ready_i |=> ram_valid_o && $stable(ram_data_o))
        else $error("stalled ram word changed");
    a_ovf_pulse: assert property (ram_overflow_o |=> !ram_overflow_o)
        else $error("overflow pulse too long");
    a_two_lane_mode: assert property (two_lane_o |-> $past(interface_select_pins_i, 6) == 4'h5)
        else $error("two lane outside 3-line mode");
    a_rd_pulse: assert property (ram_rd_pulse_o |=> !ram_rd_pulse_o)
        else $error("ram read pulse too long");
endmodule

bind lcd_host_port lcd_host_props chk_u (
    .ref_clk_i, .rst_i, .interface_select_pins_i, .chip_select_n_i, .read_strobe_n_i,
    .data_oe_n_o, .sda_oe_n_o, .serial_data_out_oe_n_o, .cmd_valid_o, .param_valid_o,
    .ram_valid_o, .ram_ready_i, .ram_data_o, .ram_overflow_o, .ram_rd_pulse_o, .two_lane_o
);
`default_nettype wire

/* File: lcd_host_model.sv */
// host microcontroller model driving the display port pins
`timescale 1ns/1ns
`default_nettype none
module lcd_host_model (
    // clock
    input wire logic ref_clk_i,
    // resolved lines
    input wire logic [8:0] bus_i,
    input wire logic rx_i,
    // host pins
    output logic cs_n_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic dcx_o,
    output logic [8:0] hd_o,
    output logic hen_o,
    output logic sda_o
);
    initial begin
        {cs_n_o, wr_n_o, rd_n_o, dcx_o, hen_o, sda_o} = 6'h38;
        hd_o = 9'h0a5;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #2;
    endtask
    task automatic cs(input logic b);
        dcx_o = 1'b0;
        cs_n_o = b;
        tick(5);
    endtask
    task automatic par_wr(input logic dc, input logic [8:0] d);
        dcx_o = dc;
        hd_o = d;
        hen_o = 1'b1;
        wr_n_o = 1'b0;
        tick(3);
        wr_n_o = 1'b1;
        tick(3);
        hen_o = 1'b0;
        hd_o = ~d;
        tick(3);
    endtask
    task automatic par_rd(output logic [8:0] r);
        dcx_o = 1'b1;
        rd_n_o = 1'b0;
        tick(5);
        r = bus_i;
        rd_n_o = 1'b1;
        tick(5);
    endtask
    task automatic bitx(input logic s, input logic w, inout logic [31:0] r);
        sda_o = s;
        wr_n_o = w;
        tick(5);
        r = {r[30:0], rx_i};
        dcx_o = 1'b1;
        tick(3);
        dcx_o = 1'b0;
    endtask
    task automatic ser(input logic [31:0] v, input int n, input logic w, output logic [31:0] r);
        r = '0;
        for (int i = n - 1; i >= 0; i--) begin
            bitx(v[i], w, r);
        end
        // line inverted after last bit
        sda_o = ~sda_o;
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the display host port
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk_i, rst_i, ram_ready_i;
    logic [3:0] interface_select_pins_i;
    logic [31:0] reg_rd_data_i;
    logic [8:0] ram_rd_data_i;
    wire chip_select_n_i, write_strobe_n_i, read_strobe_n_i, cmd_data_pin_i, hen, hsda, rx, sda_i;
    wire [8:0] data_i, data_o, data_oe_n_o, hd, ram_data_o;
    wire sda_o, sda_oe_n_o, serial_data_out_o, serial_data_out_oe_n_o, cmd_valid_o, param_valid_o;
    wire ram_valid_o, ram_overflow_o, ram_rd_pulse_o, two_lane_o, mode_reserved_o;
    wire [7:0] cmd_o, param_o;
    int miscompares = 0, total_checks = 0, ncmd = 0, nram = 0, novf = 0, nrd = 0;
    logic [7:0] lcmd, lpar;
    logic [8:0] lram;
    assign data_i = hen ? hd : (~data_oe_n_o & data_o) | (data_oe_n_o & hd);
    assign sda_i = sda_oe_n_o ? hsda : sda_o;
    assign rx = interface_select_pins_i[3] ? (serial_data_out_oe_n_o ? ~hsda : serial_data_out_o) : sda_i;
    lcd_host_port dut_u (.ref_clk_i, .rst_i, .interface_select_pins_i, .chip_select_n_i, .write_strobe_n_i,
        .read_strobe_n_i, .cmd_data_pin_i, .data_i, .data_o, .data_oe_n_o, .sda_i, .sda_o, .sda_oe_n_o,
        .serial_data_out_o, .serial_data_out_oe_n_o, .cmd_valid_o, .cmd_o, .param_valid_o, .param_o,
        .ram_valid_o, .ram_ready_i, .ram_data_o, .ram_overflow_o, .reg_rd_data_i, .ram_rd_data_i,
        .ram_rd_pulse_o, .two_lane_o, .mode_reserved_o);
    lcd_host_model host_u (.ref_clk_i, .bus_i(data_i), .rx_i(rx), .cs_n_o(chip_select_n_i),
        .wr_n_o(write_strobe_n_i), .rd_n_o(read_strobe_n_i), .dcx_o(cmd_data_pin_i), .hd_o(hd),
        .hen_o(hen), .sda_o(hsda));
    always @(posedge ref_clk_i) begin
        if (cmd_valid_o === 1'b1) begin
            ncmd++;
            lcmd = cmd_o;
        end
        if (param_valid_o === 1'b1) begin
            lpar = param_o;
        end
        if (ram_valid_o === 1'b1 && ram_ready_i === 1'b1) begin
            nram++;
            lram = ram_data_o;
        end
        if (ram_overflow_o === 1'b1) begin
            novf++;
        end
        if (ram_rd_pulse_o === 1'b1) begin
            nrd++;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic snd(input logic four, input logic f, input logic [7:0] b);
        logic [31:0] r;
        if (four) host_u.ser({24'h0, b}, 8, f, r);
        else host_u.ser({23'h0, f, b}, 9, 1'b1, r);
    endtask
    task automatic t_par();
        logic [8:0] r;
        int n;
        interface_select_pins_i = 4'h0;
        reg_rd_data_i = 32'h8c4e2d71;
        host_u.tick(5);
        n = ncmd;
        host_u.par_wr(1'b0, 9'h03a);
        chk(ncmd, n);
        host_u.cs(1'b0);
        host_u.par_wr(1'b0, 9'h03a);
        host_u.par_wr(1'b1, 9'h055);
        chk(lcmd, 8'h3a);
        chk(lpar, 8'h55);
        host_u.par_wr(1'b0, 9'h004);
        host_u.par_rd(r);
        chk(r[7:0], reg_rd_data_i[31:24]);
        host_u.par_rd(r);
        chk(r[7:0], reg_rd_data_i[23:16]);
        host_u.cs(1'b1);
        $display("test parallel done");
    endtask
    task automatic t_par9();
        logic [8:0] r;
        int n, m;
        interface_select_pins_i = 4'h2;
        ram_rd_data_i = 9'h0b6;
        ram_ready_i = 1'b0;
        host_u.cs(1'b0);
        host_u.par_wr(1'b0, 9'h03a);
        host_u.par_wr(1'b1, 9'h1c3);
        chk(lpar, 8'hc3);
        host_u.par_wr(1'b0, 9'h02c);
        n = novf;
        for (int i = 0; i < 17; i++) begin
            host_u.par_wr(1'b1, 9'h100 + 9'(i));
        end
        chk(novf, n + 1);
        m = nram;
        ram_ready_i = 1'b1;
        host_u.tick(20);
        chk(nram, m + 16);
        chk(lram, 9'h10f);
        host_u.par_wr(1'b0, 9'h02e);
        n = nrd;
        host_u.par_rd(r);
        chk(r, ram_rd_data_i);
        chk(nrd, n + 1);
        host_u.cs(1'b1);
        $display("test nine bit done");
    endtask
    task automatic t_ser3();
        logic [31:0] r;
        int n;
        interface_select_pins_i = 4'h5;
        host_u.tick(5);
        host_u.cs(1'b0);
        host_u.ser({14'h0, 1'b0, 8'h3a, 1'b1, 8'h96}, 18, 1'b1, r);
        host_u.cs(1'b1);
        chk(lcmd, 8'h3a);
        chk(lpar, 8'h96);
        n = ncmd;
        host_u.cs(1'b0);
        host_u.ser(32'h1, 5, 1'b1, r);
        host_u.cs(1'b1);
        host_u.cs(1'b0);
        host_u.ser(32'h29, 9, 1'b1, r);
        host_u.cs(1'b1);
        chk(ncmd, n + 1);
        chk(lcmd, 8'h29);
        $display("test serial write done");
    endtask
    task automatic t_rd(input logic [3:0] m);
        logic [31:0] r;
        logic [7:0] op [3] = '{8'h0a, 8'h04, 8'h09};
        int len [3] = '{8, 24, 32};
        interface_select_pins_i = m;
        reg_rd_data_i = {m, ~m, 24'h4e2d71};
        host_u.tick(5);
        for (int k = 0; k < 3; k++) begin
            host_u.cs(1'b0);
            snd(m[1], 1'b0, op[k]);
            host_u.ser(32'h55555555, len[k], 1'b1, r);
            host_u.cs(1'b1);
            chk(r, reg_rd_data_i >> (32 - len[k]));
        end
        host_u.cs(1'b0);
        snd(m[1], 1'b0, 8'h3a);
        snd(m[1], 1'b1, 8'h5a);
        host_u.cs(1'b1);
        chk(lpar, 8'h5a);
        $display("test serial read done");
    endtask
    task automatic t_lane();
        logic [31:0] r;
        logic [7:0] lb = 8'hc9;
        int n;
        interface_select_pins_i = 4'h5;
        host_u.tick(5);
        host_u.cs(1'b0);
        snd(1'b0, 1'b0, 8'he7);
        snd(1'b0, 1'b1, 8'h10);
        snd(1'b0, 1'b0, 8'h2c);
        n = nram;
        host_u.ser(32'h1, 1, 1'b1, r);
        for (int k = 3; k >= 0; k--) begin
            host_u.bitx(lb[2 * k + 1], lb[2 * k], r);
        end
        host_u.cs(1'b1);
        chk(two_lane_o, 1'b1);
        chk(nram, n + 1);
        chk(lram, 9'h0c9);
        interface_select_pins_i = 4'h1;
        host_u.tick(8);
        chk({two_lane_o, mode_reserved_o}, 2'b01);
        $display("test two lane done");
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        rst_i = 1'b1;
        ram_ready_i = 1'b0;
        interface_select_pins_i = 4'h0;
        reg_rd_data_i = 32'h00000000;
        ram_rd_data_i = 9'h000;
        repeat (10) @(posedge ref_clk_i);
        #2;
        rst_i = 1'b0;
        host_u.tick(3);
        t_par();
        t_par9();
        t_ser3();
        t_rd(4'h5);
        t_rd(4'h6);
        t_rd(4'hd);
        t_rd(4'he);
        t_lane();
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        miscompares++;
        finish_test();
    end
endmodule
`default_nettype wire
